// file: hdl/dsw_pkg.sv
package dsw_pkg;
    // Register codes, also valid command bytes
    localparam logic [7:0] REG_NV0 = 8'h00;
    localparam logic [7:0] REG_NV1 = 8'h01;
    localparam logic [7:0] REG_INPUTS = 8'hff;
    // Override command field layout
    localparam logic [4:0] CMD_OV_PREFIX = 5'h1f;
    localparam int PFX_MSB = 7;
    localparam int PFX_LSB = 3;
    localparam int OV_HI_BIT = 2;
    localparam int OV_IN_BIT = 1;
    localparam int OV_OFF_BIT = 0;
    // Setting layout
    localparam int NV_W = 6;
    localparam int IN_W = 5;
    localparam int AUX_BIT = 5;
    localparam int RW_BIT = 0;
    localparam logic [5:0] NV_DEFAULT = 6'h00;
    localparam logic [1:0] NV_PAD = 2'h0;
    localparam logic [2:0] IN_PAD = 3'h0;
    localparam logic [1:0] WR_MAX = 2'h2;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // Target address upper bits, arbitrary value
    localparam logic [4:0] ADDR_HI_DEFAULT = 5'h0c;
    // Busy time after programming
    localparam int BUSY_TIME_US = 3600;
    localparam int CLK_PERIOD_PS = 4000;
    // Divide first, the plain product overflows a 32-bit int
    localparam int BUSY_CYCLES_DEF = BUSY_TIME_US * (1000000 / CLK_PERIOD_PS);
    localparam int BUSY_W = 20;

    typedef enum logic [2:0] {
        CK_NV0, CK_NV1, CK_INPUTS, CK_OV_NV0, CK_OV_NV1, CK_OV_IN,
        CK_OV_OFF, CK_BAD
    } dsw_cmd_t;

    typedef enum logic [1:0] {SRC_NV0, SRC_NV1, SRC_IN} dsw_src_t;

    function automatic dsw_cmd_t dsw_cmd_kind(input logic [7:0] b);
        dsw_cmd_t k;
        k = CK_BAD;
        if (b == REG_NV0) begin
            k = CK_NV0;
        end else if (b == REG_NV1) begin
            k = CK_NV1;
        end else if (b == REG_INPUTS) begin
            k = CK_INPUTS;
        end else if (b[PFX_MSB:PFX_LSB] == CMD_OV_PREFIX) begin
            if (b[OV_OFF_BIT]) k = CK_OV_OFF;
            else if (b[OV_IN_BIT]) k = CK_OV_IN;
            else if (b[OV_HI_BIT]) k = CK_OV_NV1;
            else k = CK_OV_NV0;
        end
        return k;
    endfunction : dsw_cmd_kind
endpackage : dsw_pkg

// file: hdl/dsw_link_if.sv
interface dsw_link_if;
    logic start;
    logic stop;
    logic rx_stb;
    logic rx_first;
    logic rd;
    logic tx_stb;
    logic sda_oe;
    logic ack_ok;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    modport engine(output start, stop, rx_stb, rx_first, rd, tx_stb, sda_oe,
        rx_data, input ack_ok, tx_data);
    modport ctrl(input start, stop, rx_stb, rx_first, rd, tx_stb, sda_oe,
        rx_data, output ack_ok, tx_data);
endinterface : dsw_link_if

// file: hdl/dsw_i2c_link.sv
module dsw_i2c_link (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // Byte side
    dsw_link_if.engine lk
);
    localparam logic [2:0] BYTE_LAST = dsw_pkg::BYTE_LAST;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_DEC, ST_ACK, ST_TX, ST_MACK}
        dsw_link_st_t;
    dsw_link_st_t st;
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d, ackr, mack;
    logic [2:0] cnt;
    logic [7:0] sh, tsh;

    // Oversampled pins: start and stop need SDA seen while SCL is high
    wire scl_rise = scl_s[1] & ~scl_d;
    wire scl_fall = ~scl_s[1] & scl_d;
    wire start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign lk.rx_data = sh;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_i) begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= ST_IDLE;
            cnt <= 3'h0;
            sh <= 8'h00;
            tsh <= 8'h00;
            ackr <= 1'b0;
            mack <= 1'b0;
            lk.rx_first <= 1'b0;
            lk.rd <= 1'b0;
            lk.sda_oe <= 1'b0;
            lk.start <= 1'b0;
            lk.stop <= 1'b0;
            lk.rx_stb <= 1'b0;
            lk.tx_stb <= 1'b0;
        end else if (ce_i) begin
            lk.start <= 1'b0;
            lk.stop <= 1'b0;
            lk.rx_stb <= 1'b0;
            lk.tx_stb <= 1'b0;
            if (start_c) begin
                st <= ST_RX;
                cnt <= 3'h0;
                lk.rx_first <= 1'b1;
                lk.sda_oe <= 1'b0;
                lk.start <= 1'b1;
            end else if (stop_c) begin
                st <= ST_IDLE;
                lk.sda_oe <= 1'b0;
                lk.stop <= 1'b1;
            end else begin
                case (st)
                    ST_RX: if (scl_rise) begin
                        sh <= {sh[6:0], sda_s[1]};
                        cnt <= cnt + 3'h1;
                        if (cnt == BYTE_LAST) begin
                            lk.rx_stb <= 1'b1;
                            st <= ST_DEC;
                        end
                    end
                    ST_DEC: begin
                        ackr <= lk.ack_ok;
                        if (lk.rx_first) lk.rd <= sh[dsw_pkg::RW_BIT];
                        st <= ST_ACK;
                    end
                    ST_ACK: if (scl_fall) begin
                        if (!ackr) begin
                            st <= ST_IDLE;
                        end else if (!lk.sda_oe) begin
                            lk.sda_oe <= 1'b1;
                        end else begin
                            lk.rx_first <= 1'b0;
                            cnt <= 3'h0;
                            if (lk.rd) begin
                                tsh <= lk.tx_data;
                                lk.sda_oe <= ~lk.tx_data[7];
                                lk.tx_stb <= 1'b1;
                                st <= ST_TX;
                            end else begin
                                lk.sda_oe <= 1'b0;
                                st <= ST_RX;
                            end
                        end
                    end
                    ST_TX: if (scl_fall) begin
                        if (cnt == BYTE_LAST) begin
                            lk.sda_oe <= 1'b0;
                            st <= ST_MACK;
                        end else begin
                            tsh <= {tsh[6:0], 1'b0};
                            lk.sda_oe <= ~tsh[6];
                            cnt <= cnt + 3'h1;
                        end
                    end
                    ST_MACK: if (scl_rise) begin
                        mack <= ~sda_s[1];
                    end else if (scl_fall) begin
                        cnt <= 3'h0;
                        if (mack) begin
                            tsh <= lk.tx_data;
                            lk.sda_oe <= ~lk.tx_data[7];
                            lk.tx_stb <= 1'b1;
                            st <= ST_TX;
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                    default: st <= ST_IDLE;
                endcase
            end
        end
    end

endmodule : dsw_i2c_link

// file: hdl/dsw_out_mux.sv
module dsw_out_mux (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Sources
    input wire logic [5:0] nv0_i,
    input wire logic [5:0] nv1_i,
    input wire logic [4:0] sw_i,
    // Selection
    input wire logic sel_lo_i,
    input wire logic sel_hi_i,
    input wire logic ovr_en_i,
    input wire dsw_pkg::dsw_src_t ovr_src_i,
    // Outputs
    output logic [4:0] mux_o,
    output logic aux_o
);
    // Pins steer only while no override stands
    wire sel_nv1 = ovr_en_i ? (ovr_src_i == dsw_pkg::SRC_NV1)
        : !sel_hi_i;
    wire use_in = ovr_en_i ? (ovr_src_i == dsw_pkg::SRC_IN)
        : sel_lo_i;
    wire aux_follow = ovr_en_i ? (ovr_src_i != dsw_pkg::SRC_IN)
        : !sel_lo_i;
    wire [5:0] nv_pick = sel_nv1 ? nv1_i : nv0_i;
    wire [4:0] next_mux = use_in ? sw_i : nv_pick[4:0];
    wire next_aux = aux_follow ? nv_pick[dsw_pkg::AUX_BIT] : aux_o;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mux_o <= 5'h00;
            aux_o <= 1'b0;
        end else if (ce_i) begin
            mux_o <= next_mux;
            aux_o <= next_aux;
        end
    end

    a_aux_latch_hold:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !ovr_en_i && sel_lo_i) |=> $stable(aux_o))
    else $error("Aux output moved while latched");
endmodule : dsw_out_mux

// file: hdl/dsw_top.sv
// Contract
// - First written byte is a command; reserved codes are not acknowledged.
// - Codes f8 and fc drive outputs from setting 0 or 1, overriding pins.
// - Codes 11111x10 drive the five outputs from the switch inputs.
// - Codes 11111xx1 other than ff cancel the override; pins choose the source again.
// - Setting command plus data programs that setting at stop, if unlocked.
// - A second data byte programs the other setting at the same stop.
// - A third data byte is refused and nothing is programmed.
// - Each setting byte read under command 00 or 01, or accepted write, moves the pointer to the other setting; reads under other commands leave it.
// - Reads after ff return switch inputs in bits 4..0, zeros above.
// - Reads after 01 start from setting 1.
// - Setting byte holds aux in bit 5, outputs in 4..0; 7..6 read zero.
// - Both settings start as all zeros.
// - Data after an override command is not acknowledged.
// - Read data depends on the most recently written command.
// - Aux output follows its source while low select is 0, else holds.
// - Aux output carries bit 5 of the chosen setting.
// - Own address is not acknowledged for 3.6 ms after programming.
// - With write lock high, command acked but data refused, nothing stored.
// - Low select 0: outputs from setting 0 if high select 1, else 1.
// - Low select 1: outputs follow switches, aux latched from a setting.
// - Pin selection applies only while no override is in effect.
// - Reset initialises volatile registers and the bus machine.
module dsw_top #(
    parameter int BUSY_CYCLES = dsw_pkg::BUSY_CYCLES_DEF,
    parameter logic [4:0] ADDR_HI = dsw_pkg::ADDR_HI_DEFAULT
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Address straps and controls
    input wire logic [1:0] addr_i,
    input wire logic wp_i,
    input wire logic sel_lo_i,
    input wire logic sel_hi_i,
    // Switch inputs and selected outputs
    input wire logic [4:0] sw_in_i,
    output logic [4:0] mux_o,
    output logic aux_o
);
    localparam int PIN_W = 10;
    localparam int BUSY_W = dsw_pkg::BUSY_W;
    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES - 1);

    dsw_link_if lk();

    // Pin synchronisers
    logic [PIN_W-1:0] pin_s1, pin_s2;
    wire [PIN_W-1:0] pin_raw = {wp_i, sel_hi_i, sel_lo_i, addr_i, sw_in_i};
    wire [4:0] sw_s = pin_s2[4:0];
    wire [1:0] addr_s = pin_s2[6:5];
    wire sel_lo_s = pin_s2[7];
    wire sel_hi_s = pin_s2[8];
    wire wp_s = pin_s2[9];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (ce_i) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // Settings survive reset, so they carry a power-up value only
    logic [5:0] nv [2] = '{dsw_pkg::NV_DEFAULT, dsw_pkg::NV_DEFAULT};
    logic [5:0] pend [2];
    logic [1:0] pend_v;

    dsw_pkg::dsw_cmd_t cmd;
    dsw_pkg::dsw_src_t ovr_src;
    logic ovr_en;
    logic in_cmd;
    logic ptr;
    logic bad;
    logic busy;
    logic [1:0] wcnt;
    logic [BUSY_W-1:0] busy_cnt;

    // Byte decoding
    dsw_pkg::dsw_cmd_t rx_kind;
    assign rx_kind = dsw_pkg::dsw_cmd_kind(lk.rx_data);
    wire addr_match = lk.rx_data[7:1] == {ADDR_HI, addr_s};
    wire cmd_is_nv = (cmd == dsw_pkg::CK_NV0) || (cmd == dsw_pkg::CK_NV1);
    wire data_ok = cmd_is_nv && !wp_s && (wcnt < dsw_pkg::WR_MAX);
    wire addr_ok = addr_match && !busy;
    wire cmd_ok = rx_kind != dsw_pkg::CK_BAD;
    // Override and input-register commands take no data
    assign lk.ack_ok = lk.rx_first ? addr_ok
        : (in_cmd ? cmd_ok : data_ok);
    wire rx_addr = lk.rx_stb && lk.rx_first;
    wire rx_cmd = lk.rx_stb && !lk.rx_first && in_cmd;
    wire rx_dat = lk.rx_stb && !lk.rx_first && !in_cmd;
    wire commit = lk.stop && (|pend_v) && !bad;

    // Read data
    wire [5:0] nv_rd = ptr ? nv[1] : nv[0];
    assign lk.tx_data = (cmd == dsw_pkg::CK_INPUTS)
        ? {dsw_pkg::IN_PAD, sw_s}
        : {dsw_pkg::NV_PAD, nv_rd};

    // Transfer context
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            in_cmd <= 1'b0;
            wcnt <= 2'h0;
            bad <= 1'b0;
        end else if (ce_i) begin
            if (lk.start) begin
                in_cmd <= 1'b0;
                wcnt <= 2'h0;
                bad <= 1'b0;
            end else if (rx_addr) begin
                in_cmd <= lk.ack_ok && !lk.rx_data[dsw_pkg::RW_BIT];
            end else if (rx_cmd) begin
                in_cmd <= 1'b0;
            end else if (rx_dat) begin
                if (data_ok) begin
                    wcnt <= wcnt + 2'h1;
                end else if (cmd_is_nv && wcnt == dsw_pkg::WR_MAX) begin
                    bad <= 1'b1;
                end
            end
        end
    end

    // Command, pointer and override
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd <= dsw_pkg::CK_NV0;
            ptr <= 1'b0;
            ovr_en <= 1'b0;
            ovr_src <= dsw_pkg::SRC_NV0;
        end else if (ce_i) begin
            if (rx_cmd && cmd_ok) begin
                cmd <= rx_kind;
                case (rx_kind)
                    dsw_pkg::CK_NV0: ptr <= 1'b0;
                    dsw_pkg::CK_NV1: ptr <= 1'b1;
                    dsw_pkg::CK_OV_NV0: begin
                        ovr_en <= 1'b1;
                        ovr_src <= dsw_pkg::SRC_NV0;
                    end
                    dsw_pkg::CK_OV_NV1: begin
                        ovr_en <= 1'b1;
                        ovr_src <= dsw_pkg::SRC_NV1;
                    end
                    dsw_pkg::CK_OV_IN: begin
                        ovr_en <= 1'b1;
                        ovr_src <= dsw_pkg::SRC_IN;
                    end
                    dsw_pkg::CK_OV_OFF: ovr_en <= 1'b0;
                    default: ptr <= ptr;
                endcase
            end else if ((rx_dat && data_ok) || (lk.tx_stb && cmd_is_nv)) begin
                ptr <= ~ptr;
            end
        end
    end

    // Pending bytes, programmed only at stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pend_v <= 2'h0;
            pend[0] <= dsw_pkg::NV_DEFAULT;
            pend[1] <= dsw_pkg::NV_DEFAULT;
        end else if (ce_i) begin
            if (lk.start || lk.stop) begin
                pend_v <= 2'h0;
            end else if (rx_dat && data_ok) begin
                pend[ptr] <= lk.rx_data[5:0];
                pend_v[ptr] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && commit) begin
            if (pend_v[0]) nv[0] <= pend[0];
            if (pend_v[1]) nv[1] <= pend[1];
        end
    end

    // Busy window after programming
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy <= 1'b0;
            busy_cnt <= '0;
        end else if (ce_i) begin
            if (commit) begin
                busy <= 1'b1;
                busy_cnt <= BUSY_LOAD;
            end else if (busy) begin
                if (busy_cnt == '0) busy <= 1'b0;
                else busy_cnt <= busy_cnt - BUSY_W'(1);
            end
        end
    end

    // SDA only ever pulls low
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) sda_o <= 1'b0;
        else sda_o <= 1'b0;
    end
    assign sda_oe_o = lk.sda_oe;

    dsw_i2c_link u_link (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lk(lk)
    );

    dsw_out_mux u_mux (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .nv0_i(nv[0]),
        .nv1_i(nv[1]),
        .sw_i(sw_s),
        .sel_lo_i(sel_lo_s),
        .sel_hi_i(sel_hi_s),
        .ovr_en_i(ovr_en),
        .ovr_src_i(ovr_src),
        .mux_o(mux_o),
        .aux_o(aux_o)
    );

    a_bad_cmd_nack:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (lk.rx_stb && !lk.rx_first && in_cmd && rx_kind == dsw_pkg::CK_BAD)
        |-> !lk.ack_ok)
    else $error("Reserved command acknowledged");

    a_ovr_nv_set:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_cmd && lk.rx_data == 8'hfc)
        |=> (ovr_en && ovr_src == dsw_pkg::SRC_NV1))
    else $error("Override to setting 1 not taken");

    a_ovr_in_set:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_cmd && lk.rx_data[7:3] == 5'h1f
        && lk.rx_data[1:0] == 2'h2) |=> (ovr_en && ovr_src == dsw_pkg::SRC_IN))
    else $error("Override to inputs not taken");

    a_ovr_cancel:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_cmd && rx_kind == dsw_pkg::CK_OV_OFF) |=> !ovr_en)
    else $error("Override not cancelled");

    a_commit_busy:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && lk.stop && pend_v != 2'h0 && !bad) |=> busy)
    else $error("Programming did not start busy window");

    a_extra_nack:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rx_dat && wcnt == 2'h2) |-> !lk.ack_ok)
    else $error("Third data byte acknowledged");

    a_ptr_toggle:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_dat && lk.ack_ok) |=> (ptr != $past(ptr)))
    else $error("Pointer did not advance");

    a_input_read:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd == dsw_pkg::CK_INPUTS) |-> (lk.tx_data == {3'h0, sw_s}))
    else $error("Input read data wrong");

    a_ovr_data_nack:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rx_dat && !cmd_is_nv) |-> !lk.ack_ok)
    else $error("Data after override acknowledged");

    a_busy_addr_nack:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rx_addr && busy) |-> !lk.ack_ok)
    else $error("Address acknowledged while busy");

    a_wp_data_nack:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rx_dat && wp_s) |-> !lk.ack_ok)
    else $error("Data acknowledged while locked");

    a_no_bad_commit:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && lk.stop && bad) |=> !busy || $past(busy))
    else $error("Programming after refused byte");

    a_nv0_commit:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && commit && pend_v[0]) |=> (nv[0] == $past(pend[0])))
    else $error("Setting 0 not programmed at stop");

    a_nv1_commit:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && commit && pend_v[1]) |=> (nv[1] == $past(pend[1])))
    else $error("Setting 1 not programmed at stop");

    a_rd_nv1_sel:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_cmd && rx_kind == dsw_pkg::CK_NV1)
        |=> (lk.tx_data == {dsw_pkg::NV_PAD, nv[1]}))
    else $error("Read after 01 not from setting 1");

    a_rd_nv0_sel:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_cmd && rx_kind == dsw_pkg::CK_NV0)
        |=> (lk.tx_data == {dsw_pkg::NV_PAD, nv[0]}))
    else $error("Read after 00 not from setting 0");

    a_aux_nv1_ovr:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && ovr_en && ovr_src == dsw_pkg::SRC_NV1)
        |=> (aux_o == $past(nv[1][dsw_pkg::AUX_BIT])))
    else $error("Aux output not from setting 1");

    a_lock_no_pend:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rx_dat && wp_s) |=> $stable(pend_v))
    else $error("Data stored while locked");

    a_pin_nv0_out:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !ovr_en && !sel_lo_s && sel_hi_s)
        |=> (mux_o == $past(nv[0][dsw_pkg::IN_W-1:0])))
    else $error("Outputs not from setting 0");

    a_pin_sw_out:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !ovr_en && sel_lo_s) |=> (mux_o == $past(sw_s)))
    else $error("Outputs not from switch inputs");

    a_reset_defaults:
    assert property (@(posedge clk_i)
        sys_rst_i |=> (!ovr_en && !ptr && !busy))
    else $error("State not at default after reset");

    a_ovr_stands:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !rx_cmd) |=> $stable(ovr_en))
    else $error("Override changed without command");
endmodule : dsw_top

// file: sim/dsw_i2c_ctrl.sv
module dsw_i2c_ctrl (
    // Link clock
    input wire logic lclk_i,
    // Bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end
    // SCL only moves inside frames
    task automatic hp();
        repeat (4) @(posedge lclk_i);
    endtask : hp
    task automatic start();
        sda_low_o <= 1'h1;
        hp();
        scl_o <= 1'h0;
        hp();
    endtask : start
    task automatic stop();
        sda_low_o <= 1'h1;
        hp();
        scl_o <= 1'h1;
        hp();
        sda_low_o <= 1'h0;
        hp();
    endtask : stop
    // Data moves only a quarter period after SCL fell
    task automatic put_bit(input logic b, output logic s);
        sda_low_o <= !b;
        hp();
        scl_o <= 1'h1;
        hp();
        hp();
        s = sda_i;
        scl_o <= 1'h0;
        hp();
    endtask : put_bit
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'h1, s);
        ack = !s;
    endtask : wr_byte
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            put_bit(1'h1, s);
            d = {d[6:0], s};
        end
        put_bit(!more, s);
    endtask : rd_byte
endmodule : dsw_i2c_ctrl

// file: sim/tb_i2c_nv_dip_switch_mux.sv
module tb_i2c_nv_dip_switch_mux;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADDR = {dsw_pkg::ADDR_HI_DEFAULT, 2'h2};
    localparam logic [7:0] OV_C [5] = '{8'hfa, 8'hf8, 8'hfd, 8'hfc, 8'hfb};
    localparam logic [4:0] OV_E [5] = '{5'h13, 5'h0a, 5'h13, 5'h15, 5'h13};
    logic clk_i, lclk, sys_rst_i, wp_i, sel_lo_i, sel_hi_i;
    logic sda_o, sda_oe_o, scl, sda_low, sda_bus, aux_o;
    logic [4:0] sw_in_i, mux_o;
    int failures = 0;
    int comparisons = 0;
    // Pull-up: low if either party pulls
    assign sda_bus = !(sda_low || (sda_oe_o && !sda_o));
    dsw_top #(.BUSY_CYCLES(1000)) u_dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(1'h1), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_i(2'h2), .wp_i(wp_i),
        .sel_lo_i(sel_lo_i), .sel_hi_i(sel_hi_i), .sw_in_i(sw_in_i),
        .mux_o(mux_o), .aux_o(aux_o));
    dsw_i2c_ctrl u_ctrl (.lclk_i(lclk), .sda_i(sda_bus), .scl_o(scl),
        .sda_low_o(sda_low));
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = !clk_i;
    end
    initial begin
        lclk = 1'h0;
        #3.3;
        forever #7.5 lclk = !lclk;
    end
    task automatic report_and_stop();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_ctrl.wr_byte(b, a);
        chk({7'h0, a}, {7'h0, exp_ack});
    endtask : send
    task automatic cmd(input logic [7:0] c);
        u_ctrl.start();
        send({ADDR, 1'h0}, 1'h1);
        send(c, 1'h1);
    endtask : cmd
    task automatic rd(input int n, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] d;
        u_ctrl.start();
        send({ADDR, 1'h1}, 1'h1);
        for (int i = 0; i < n; i++) begin
            u_ctrl.rd_byte(i < n - 1, d);
            chk(d, (i % 2) ? e1 : e0);
        end
        u_ctrl.stop();
    endtask : rd
    task automatic pins(input logic lo, input logic hi, input logic [5:0] e);
        @(negedge clk_i);
        sel_lo_i = lo;
        sel_hi_i = hi;
        repeat (10) @(negedge clk_i);
        chk({2'h0, aux_o, mux_o}, {2'h0, e});
    endtask : pins
    initial begin
        sys_rst_i = 1'h1;
        wp_i = 1'h0;
        sel_lo_i = 1'h0;
        sel_hi_i = 1'h1;
        sw_in_i = 5'h13;
        repeat (3) @(negedge clk_i);
        sys_rst_i = 1'h0;
        pins(1'h0, 1'h1, 6'h00);
        rd(3, 8'h00, 8'h00);
        cmd(dsw_pkg::REG_NV0);
        send(8'hea, 1'h1);
        send(8'h55, 1'h1);
        u_ctrl.stop();
        u_ctrl.start();
        send({ADDR, 1'h0}, 1'h0);
        u_ctrl.stop();
        #5000;
        cmd(dsw_pkg::REG_NV0);
        u_ctrl.stop();
        rd(3, 8'h2a, 8'h15);
        cmd(dsw_pkg::REG_NV1);
        u_ctrl.stop();
        rd(2, 8'h15, 8'h2a);
        cmd(dsw_pkg::REG_NV0);
        send(8'h01, 1'h1);
        send(8'h02, 1'h1);
        send(8'h03, 1'h0);
        u_ctrl.stop();
        rd(2, 8'h2a, 8'h15);
        @(negedge clk_i);
        wp_i = 1'h1;
        cmd(dsw_pkg::REG_NV0);
        send(8'h00, 1'h0);
        u_ctrl.stop();
        @(negedge clk_i);
        wp_i = 1'h0;
        rd(2, 8'h2a, 8'h15);
        u_ctrl.start();
        send({ADDR, 1'h0}, 1'h1);
        send(8'h02, 1'h0);
        u_ctrl.stop();
        cmd(dsw_pkg::REG_INPUTS);
        u_ctrl.stop();
        rd(1, 8'h13, 8'h13);
        pins(1'h0, 1'h1, 6'h2a);
        pins(1'h0, 1'h0, 6'h15);
        pins(1'h1, 1'h0, 6'h13);
        pins(1'h1, 1'h1, 6'h13);
        for (int i = 0; i < 5; i++) begin
            cmd(OV_C[i]);
            send(8'h00, 1'h0);
            u_ctrl.stop();
            repeat (10) @(negedge clk_i);
            chk({3'h0, mux_o}, {3'h0, OV_E[i]});
        end
        pins(1'h0, 1'h1, 6'h2a);
        report_and_stop();
    end
    initial begin
        #350000;
        failures++;
        report_and_stop();
    end
endmodule : tb_i2c_nv_dip_switch_mux
